/* rtl/msc_consts.svh */
// offsets, field positions, reset values and timing counts of one serial channel
// assumes inclusion by msc_pkg users; definitions only
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH

// register word indices; byte address is four times the index
`define MSC_IDX_DATA      4'h0
`define MSC_IDX_IEN       4'h1
`define MSC_IDX_IID       4'h2
`define MSC_IDX_LCTL      4'h3
`define MSC_IDX_MCTL      4'h4
`define MSC_IDX_LSTAT     4'h5
`define MSC_IDX_MSTAT     4'h6
`define MSC_IDX_SCRATCH   4'h7
`define MSC_IDX_ADPCTL    4'h8

// line control fields
`define MSC_LC_PAR_EN     3
`define MSC_LC_EVEN       4
`define MSC_LC_BREAK      6
`define MSC_LC_DLAB       7
`define MSC_LC_STOP       2

// adapter control fields
`define MSC_AC_PCHK       3
`define MSC_AC_APERR      4
`define MSC_AC_DPERR      5

// reset values
`define MSC_RST_LSTAT     8'h60
`define MSC_RST_DIV       16'h0050
`define MSC_RST_ADPCTL    8'h08

// timing: reference derived from the 100 MHz clock by a fractional accumulator
`define MSC_CLK_KHZ       100000
`define MSC_REF_KHZ       12288
`define MSC_CTRL_MHZ      40
`define MSC_OVERSAMPLE    16
`define MSC_FIFO_DEPTH    16

`endif

/* rtl/msc_pkg.sv */
// types shared by the serial channel
// assumes msc_consts.svh for numeric constants
package msc_pkg;

  typedef enum logic [2:0] {
    MSC_IDLE,
    MSC_START,
    MSC_DATA,
    MSC_PARITY,
    MSC_STOP
  } msc_state_t;

  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } msc_rx_ent_t;

  typedef struct packed {
    logic ri;
    logic dcd;
    logic dsr;
    logic cts;
  } msc_modem_in_t;

  typedef struct packed {
    logic dtr;
    logic rts;
  } msc_modem_out_t;

endpackage

/* rtl/msc_channel.sv */
// one asynchronous serial channel with its host-side control section
// assumes an avalon-mm master on clk and synchronous serial/modem inputs
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "msc_consts.svh"

module msc_channel
  import msc_pkg::*;
#(
  parameter logic [7:0] CHAN_ID = 8'h00
) (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // avalon-mm register slave
  input  wire logic [3:0]     avs_address,
  input  wire logic           avs_read,
  input  wire logic           avs_write,
  input  wire logic [31:0]    avs_writedata,
  input  wire logic [3:0]     avs_byteenable,
  output logic      [31:0]    avs_readdata,
  output logic                avs_waitrequest,
  output logic      [1:0]     avs_response,
  // bus parity
  input  wire logic           addr_parity,
  input  wire logic [1:0]     wdata_parity,
  output logic      [1:0]     rdata_parity,
  // interrupt request lines, open drain
  output logic      [7:0]     irq_out,
  output logic      [7:0]     irq_oe_n,
  // serial line and modem controls
  output logic                txd,
  input  wire logic           rxd,
  output msc_modem_out_t      modem_out,
  input  wire msc_modem_in_t  modem_in
);

  // ****************************************************************
  // functions
  // ****************************************************************
  // parity of the low nbits of a character, nbits coded as length minus five
  function automatic logic char_par(input logic [7:0] d, input logic [1:0] len);
    logic [7:0] m;
    m = 8'h1F;
    case (len)
      2'd1:    m = 8'h3F;
      2'd2:    m = 8'h7F;
      2'd3:    m = 8'hFF;
      default: m = 8'h1F;
    endcase
    return ^(d & m);
  endfunction

  function automatic logic [4:0] cnt_inc(input logic [4:0] c);
    return 5'(c + 5'd1);
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  ien_reg, lctl_reg, mctl_reg, scratch_reg, adpctl_reg;
  logic [15:0] div_reg;
  logic        fifo_en_reg;
  logic        oe_reg, pe_reg, fe_reg, bi_reg;
  logic        thre_pend_reg;
  logic [3:0]  mdelta_reg;
  msc_modem_in_t modem_prev_reg;
  logic        ack_reg;
  logic [31:0] readdata_reg;
  logic [1:0]  resp_reg, rpar_reg;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire        req      = (avs_read | avs_write) & ~ack_reg;
  wire        addr_ok  = avs_address <= `MSC_IDX_ADPCTL;
  wire        apar_ok  = ^{avs_address, addr_parity};
  wire        dpar_ok  = ~avs_write | ~avs_byteenable[0]
                         | (^{avs_writedata[7:0], wdata_parity[0]});
  wire        acc_ok   = addr_ok & apar_ok & dpar_ok;
  wire        do_wr    = req & avs_write & acc_ok & avs_byteenable[0];
  wire        do_rd    = req & avs_read & acc_ok;
  wire [7:0]  wbyte    = avs_writedata[7:0];
  wire        dlab     = lctl_reg[`MSC_LC_DLAB];
  wire        at_data  = avs_address == `MSC_IDX_DATA;
  wire        at_ien   = avs_address == `MSC_IDX_IEN;
  // per-register strobes handed to the channel logic
  wire        wr_thr   = do_wr & at_data & ~dlab;
  wire        wr_dll   = do_wr & at_data & dlab;
  wire        wr_dlm   = do_wr & at_ien & dlab;
  wire        wr_ien   = do_wr & at_ien & ~dlab;
  wire        wr_fctl  = do_wr & (avs_address == `MSC_IDX_IID);
  wire        wr_lctl  = do_wr & (avs_address == `MSC_IDX_LCTL);
  wire        wr_mctl  = do_wr & (avs_address == `MSC_IDX_MCTL);
  wire        wr_scr   = do_wr & (avs_address == `MSC_IDX_SCRATCH);
  wire        wr_adp   = do_wr & (avs_address == `MSC_IDX_ADPCTL);
  wire        rd_rbr   = do_rd & at_data & ~dlab;
  wire        rd_iid   = do_rd & (avs_address == `MSC_IDX_IID);
  wire        rd_lstat = do_rd & (avs_address == `MSC_IDX_LSTAT);
  wire        rd_mstat = do_rd & (avs_address == `MSC_IDX_MSTAT);

  // ****************************************************************
  // bit timing
  // ****************************************************************
  // fractional accumulator turns the system clock into the 12.288 MHz reference
  logic [16:0] ref_acc_reg;
  logic [15:0] div_cnt_reg;
  wire  [16:0] ref_sum  = 17'(ref_acc_reg + 17'(`MSC_REF_KHZ));
  wire         ref_tick = ref_sum >= 17'(`MSC_CLK_KHZ);
  wire  [15:0] div_eff  = (div_reg == 16'h0000) ? 16'h0001 : div_reg;
  wire         tick     = ref_tick & (div_cnt_reg >= 16'(div_eff - 16'h0001));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_acc_reg <= 17'h0_0000;
      div_cnt_reg <= 16'h0000;
    end else begin
      ref_acc_reg <= ref_tick ? 17'(ref_sum - 17'(`MSC_CLK_KHZ)) : ref_sum;
      if (tick | wr_dll | wr_dlm)
        div_cnt_reg <= 16'h0000;
      else if (ref_tick)
        div_cnt_reg <= 16'(div_cnt_reg + 16'h0001);
    end
  end

  // ****************************************************************
  // fifos
  // ****************************************************************
  // depth one when fifo mode is off, so the same store acts as holding register
  logic [7:0]   tx_mem [`MSC_FIFO_DEPTH];
  msc_rx_ent_t  rx_mem [`MSC_FIFO_DEPTH];
  logic [3:0]   tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
  logic [4:0]   tx_cnt_reg, rx_cnt_reg;
  wire  [4:0]   cap       = fifo_en_reg ? 5'(`MSC_FIFO_DEPTH) : 5'd1;
  wire          tx_full   = tx_cnt_reg >= cap;
  wire          tx_push   = wr_thr & ~tx_full;
  logic         tx_pop, rx_push, rx_full;
  wire          rx_pop    = rd_rbr & (rx_cnt_reg != 5'd0);
  wire          tx_clr    = wr_fctl & (wbyte[2] | (wbyte[0] != fifo_en_reg));
  wire          rx_clr    = wr_fctl & (wbyte[1] | (wbyte[0] != fifo_en_reg));
  msc_rx_ent_t  rx_new;
  assign rx_full = rx_cnt_reg >= cap;

  always_ff @(posedge clk) begin
    if (tx_push)
      tx_mem[tx_wp_reg] <= wbyte;
    if (rx_push & ~rx_full)
      rx_mem[rx_wp_reg] <= rx_new;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_wp_reg  <= 4'h0;
      tx_rp_reg  <= 4'h0;
      tx_cnt_reg <= 5'd0;
      rx_wp_reg  <= 4'h0;
      rx_rp_reg  <= 4'h0;
      rx_cnt_reg <= 5'd0;
    end else begin
      if (tx_clr) begin
        tx_wp_reg  <= 4'h0;
        tx_rp_reg  <= 4'h0;
        tx_cnt_reg <= 5'd0;
      end else begin
        tx_wp_reg  <= tx_push ? 4'(tx_wp_reg + 4'h1) : tx_wp_reg;
        tx_rp_reg  <= tx_pop ? 4'(tx_rp_reg + 4'h1) : tx_rp_reg;
        tx_cnt_reg <= 5'(tx_cnt_reg + {4'h0, tx_push} - {4'h0, tx_pop});
      end
      if (rx_clr) begin
        rx_wp_reg  <= 4'h0;
        rx_rp_reg  <= 4'h0;
        rx_cnt_reg <= 5'd0;
      end else begin
        rx_wp_reg  <= (rx_push & ~rx_full) ? 4'(rx_wp_reg + 4'h1) : rx_wp_reg;
        rx_rp_reg  <= rx_pop ? 4'(rx_rp_reg + 4'h1) : rx_rp_reg;
        rx_cnt_reg <= 5'(rx_cnt_reg + {4'h0, rx_push & ~rx_full} - {4'h0, rx_pop});
      end
    end
  end

  // ****************************************************************
  // transmitter
  // ****************************************************************
  msc_state_t tx_st_reg;
  logic [4:0] tx_tk_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_sh_reg;
  logic       tx_par_reg, txd_reg;
  wire  [2:0] last_bit = 3'({1'b0, lctl_reg[1:0]} + 3'd4);
  wire        bit_end  = tx_tk_reg == 5'd15;
  // 1.5 stop bits only with five-bit characters, as the stop field selects
  wire  [4:0] stop_end = ~lctl_reg[`MSC_LC_STOP] ? 5'd15 :
                         (lctl_reg[1:0] == 2'd0) ? 5'd23 : 5'd31;
  assign tx_pop = (tx_st_reg == MSC_IDLE) & (tx_cnt_reg != 5'd0) & tick & ~tx_clr;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_reg  <= MSC_IDLE;
      tx_tk_reg  <= 5'd0;
      tx_bit_reg <= 3'd0;
      tx_sh_reg  <= 8'h00;
      tx_par_reg <= 1'b0;
      txd_reg    <= 1'b1;
    end else if (tick) begin
      tx_tk_reg <= cnt_inc(tx_tk_reg);
      case (tx_st_reg)
        MSC_IDLE: begin
          txd_reg <= 1'b1;
          if (tx_pop) begin
            tx_sh_reg  <= tx_mem[tx_rp_reg];
            tx_par_reg <= char_par(tx_mem[tx_rp_reg], lctl_reg[1:0])
                          ^ ~lctl_reg[`MSC_LC_EVEN];
            tx_tk_reg  <= 5'd0;
            txd_reg    <= 1'b0;
            tx_st_reg  <= MSC_START;
          end
        end
        MSC_START: if (bit_end) begin
          tx_tk_reg  <= 5'd0;
          tx_bit_reg <= 3'd0;
          txd_reg    <= tx_sh_reg[0];
          tx_st_reg  <= MSC_DATA;
        end
        MSC_DATA: if (bit_end) begin
          tx_tk_reg  <= 5'd0;
          tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
          tx_bit_reg <= 3'(tx_bit_reg + 3'd1);
          if (tx_bit_reg == last_bit) begin
            txd_reg   <= lctl_reg[`MSC_LC_PAR_EN] ? tx_par_reg : 1'b1;
            tx_st_reg <= lctl_reg[`MSC_LC_PAR_EN] ? MSC_PARITY : MSC_STOP;
          end else begin
            txd_reg   <= tx_sh_reg[1];
          end
        end
        MSC_PARITY: if (bit_end) begin
          tx_tk_reg <= 5'd0;
          txd_reg   <= 1'b1;
          tx_st_reg <= MSC_STOP;
        end
        MSC_STOP: if (tx_tk_reg == stop_end) begin
          tx_tk_reg <= 5'd0;
          tx_st_reg <= MSC_IDLE;
        end
        default: tx_st_reg <= MSC_IDLE;
      endcase
    end
  end
  // break control forces space while it is set
  assign txd = txd_reg & ~lctl_reg[`MSC_LC_BREAK];

  // ****************************************************************
  // receiver
  // ****************************************************************
  // runs on its own state, sharing the tick, last_bit and the line control fields with the transmitter
  msc_state_t rx_st_reg;
  logic [4:0] rx_tk_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_sh_reg;
  logic       rx_pe_reg, rx_zero_reg, rx_hold_reg;
  wire        mid      = rx_tk_reg == 5'd15;
  wire  [7:0] rx_data  = rx_sh_reg >> (3'd3 - {1'b0, lctl_reg[1:0]});
  wire        par_fail = lctl_reg[`MSC_LC_PAR_EN] & adpctl_reg[`MSC_AC_PCHK]
                         & rx_pe_reg;
  assign rx_push = tick & (rx_st_reg == MSC_STOP) & mid;
  assign rx_new  = '{brk:  ~rxd & rx_zero_reg,
                     frm:  ~rxd,
                     par:  par_fail,
                     data: rx_data};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st_reg   <= MSC_IDLE;
      rx_tk_reg   <= 5'd0;
      rx_bit_reg  <= 3'd0;
      rx_sh_reg   <= 8'h00;
      rx_pe_reg   <= 1'b0;
      rx_zero_reg <= 1'b0;
      rx_hold_reg <= 1'b0;
    end else if (tick) begin
      rx_tk_reg <= cnt_inc(rx_tk_reg);
      case (rx_st_reg)
        MSC_IDLE: begin
          rx_hold_reg <= rx_hold_reg & ~rxd;
          if (~rxd & ~rx_hold_reg) begin
            rx_tk_reg <= 5'd0;
            rx_st_reg <= MSC_START;
          end
        end
        MSC_START: if (rx_tk_reg == 5'd7) begin
          rx_tk_reg   <= 5'd0;
          rx_bit_reg  <= 3'd0;
          rx_sh_reg   <= 8'h00;
          rx_pe_reg   <= lctl_reg[`MSC_LC_EVEN] ? 1'b0 : 1'b1;
          rx_zero_reg <= 1'b1;
          rx_st_reg   <= rxd ? MSC_IDLE : MSC_DATA;
        end
        MSC_DATA: if (mid) begin
          rx_tk_reg   <= 5'd0;
          rx_sh_reg   <= {rxd, rx_sh_reg[7:1]};
          rx_pe_reg   <= rx_pe_reg ^ rxd;
          rx_zero_reg <= rx_zero_reg & ~rxd;
          rx_bit_reg  <= 3'(rx_bit_reg + 3'd1);
          if (rx_bit_reg == last_bit)
            rx_st_reg <= lctl_reg[`MSC_LC_PAR_EN] ? MSC_PARITY : MSC_STOP;
        end
        MSC_PARITY: if (mid) begin
          rx_tk_reg   <= 5'd0;
          rx_pe_reg   <= rx_pe_reg ^ rxd;
          rx_zero_reg <= rx_zero_reg & ~rxd;
          rx_st_reg   <= MSC_STOP;
        end
        MSC_STOP: if (mid) begin
          rx_tk_reg <= 5'd0;
          // a space stop bit holds the receiver in idle, without a new start, until the line returns
          rx_hold_reg <= ~rxd;
          rx_st_reg   <= MSC_IDLE;
        end
        default: rx_st_reg <= MSC_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // status and interrupts
  // ****************************************************************
  msc_rx_ent_t rx_head;
  assign rx_head = rx_mem[rx_rp_reg];
  wire       dr      = rx_cnt_reg != 5'd0;
  wire       thre    = tx_cnt_reg == 5'd0;
  wire       temt    = thre & (tx_st_reg == MSC_IDLE);
  wire       ovr     = rx_push & rx_full;
  wire       ls_err  = oe_reg | pe_reg | fe_reg | bi_reg;
  wire [7:0] lstat   = {1'b0, temt, thre, bi_reg, fe_reg, pe_reg, oe_reg, dr};
  wire [3:0] mlevel  = {modem_in.dcd, modem_in.ri, modem_in.dsr, modem_in.cts};
  wire [3:0] mchange = {modem_in.dcd ^ modem_prev_reg.dcd,
                        ~modem_in.ri & modem_prev_reg.ri,
                        modem_in.dsr ^ modem_prev_reg.dsr,
                        modem_in.cts ^ modem_prev_reg.cts};
  // the emptying pop is caught as an event; the empty level alone would miss it
  wire       thre_set = ~thre_pend_reg & (tx_clr | (thre & wr_ien)
                        | (tx_pop & ~tx_push & (tx_cnt_reg == 5'd1)));
  logic [3:0] iid;
  // fixed priority: line status, receive data, holding empty, modem
  assign iid = (ien_reg[2] & ls_err)              ? 4'h6 :
               (ien_reg[0] & dr)                  ? 4'h4 :
               (ien_reg[1] & thre_pend_reg)       ? 4'h2 :
               (ien_reg[3] & (mdelta_reg != 4'h0)) ? 4'h0 : 4'h1;
  wire       intr    = ~iid[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_reg         <= 1'b0;
      pe_reg         <= 1'b0;
      fe_reg         <= 1'b0;
      bi_reg         <= 1'b0;
      thre_pend_reg  <= 1'b0;
      mdelta_reg     <= 4'h0;
      modem_prev_reg <= '0;
    end else begin
      // new events win over the clear caused by a status read
      oe_reg <= ovr | (oe_reg & ~rd_lstat);
      pe_reg <= (rx_push & ~rx_full & rx_new.par) | (pe_reg & ~rd_lstat);
      fe_reg <= (rx_push & ~rx_full & rx_new.frm) | (fe_reg & ~rd_lstat);
      bi_reg <= (rx_push & ~rx_full & rx_new.brk) | (bi_reg & ~rd_lstat);
      thre_pend_reg  <= thre_set
                        | (thre_pend_reg & ~wr_thr & ~(rd_iid & (iid == 4'h2)));
      mdelta_reg     <= mchange | (mdelta_reg & {4{~rd_mstat}});
      modem_prev_reg <= modem_in;
    end
  end

  // one selected line pulled low while an interrupt is pending
  always_comb begin
    irq_out  = 8'h00;
    irq_oe_n = 8'hFF;
    irq_oe_n[adpctl_reg[2:0]] = ~intr;
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ien_reg     <= 8'h00;
      lctl_reg    <= 8'h00;
      mctl_reg    <= 8'h00;
      scratch_reg <= 8'h00;
      div_reg     <= `MSC_RST_DIV;
      fifo_en_reg <= 1'b0;
      adpctl_reg  <= `MSC_RST_ADPCTL;
    end else begin
      if (wr_ien)  ien_reg     <= {4'h0, wbyte[3:0]};
      if (wr_lctl) lctl_reg    <= wbyte;
      if (wr_mctl) mctl_reg    <= {6'h00, wbyte[1:0]};
      if (wr_scr)  scratch_reg <= wbyte;
      if (wr_dll)  div_reg     <= {div_reg[15:8], wbyte};
      if (wr_dlm)  div_reg     <= {wbyte, div_reg[7:0]};
      if (wr_fctl) fifo_en_reg <= wbyte[0];
      adpctl_reg[3:0] <= wr_adp ? wbyte[3:0] : adpctl_reg[3:0];
      // parity errors are sticky; a new error wins over a write-one clear
      adpctl_reg[`MSC_AC_APERR] <= (req & ~apar_ok)
        | (adpctl_reg[`MSC_AC_APERR] & ~(wr_adp & wbyte[`MSC_AC_APERR]));
      adpctl_reg[`MSC_AC_DPERR] <= (req & ~dpar_ok)
        | (adpctl_reg[`MSC_AC_DPERR] & ~(wr_adp & wbyte[`MSC_AC_DPERR]));
      adpctl_reg[7:6] <= 2'b00;
    end
  end
  assign modem_out = '{dtr: mctl_reg[0], rts: mctl_reg[1]};

  // ****************************************************************
  // read path and answer
  // ****************************************************************
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case (avs_address)
      `MSC_IDX_DATA:    rd_mux[7:0] = dlab ? div_reg[7:0] : rx_head.data;
      `MSC_IDX_IEN:     rd_mux[7:0] = dlab ? div_reg[15:8] : ien_reg;
      `MSC_IDX_IID:     rd_mux[7:0] = {{2{fifo_en_reg}}, 2'b00, iid};
      `MSC_IDX_LCTL:    rd_mux[7:0] = lctl_reg;
      `MSC_IDX_MCTL:    rd_mux[7:0] = mctl_reg;
      `MSC_IDX_LSTAT:   rd_mux[7:0] = lstat;
      `MSC_IDX_MSTAT:   rd_mux[7:0] = {mlevel, mdelta_reg};
      `MSC_IDX_SCRATCH: rd_mux[7:0] = scratch_reg;
      `MSC_IDX_ADPCTL:  rd_mux      = {CHAN_ID, adpctl_reg};
      default:          rd_mux      = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg      <= 1'b0;
      readdata_reg <= 32'h0000_0000;
      resp_reg     <= 2'b00;
      rpar_reg     <= 2'b11;
    end else begin
      ack_reg <= req;
      if (req) begin
        // lanes outside the enabled bytes read as zero
        readdata_reg <= avs_read ? {16'h0000,
                                    rd_mux[15:8] & {8{avs_byteenable[1]}},
                                    rd_mux[7:0] & {8{avs_byteenable[0]}}}
                                 : 32'h0000_0000;
        resp_reg     <= ~addr_ok ? 2'b11 : (~apar_ok | ~dpar_ok) ? 2'b10 : 2'b00;
        rpar_reg     <= {~^(rd_mux[15:8] & {8{avs_byteenable[1]}}),
                         ~^(rd_mux[7:0] & {8{avs_byteenable[0]}})};
      end
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata    = readdata_reg;
  assign avs_response    = resp_reg;
  assign rdata_parity    = rpar_reg;

endmodule

/* dv/msc_channel_props.sv */
// checker for the channel's register slave, irq pins and tx framing
// assumes binding to msc_channel with one clock domain
`timescale 1ns/1ps
module msc_props (
  // watched ports
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic        addr_parity,
  input wire logic [1:0]  rdata_parity,
  input wire logic [7:0]  irq_out,
  input wire logic [7:0]  irq_oe_n,
  input wire logic        txd
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire ack  = (avs_read | avs_write) & ~avs_waitrequest;
  wire apok = ^{avs_address, addr_parity};
  property p_wait; (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait");
  property p_apar; ack && !apok && avs_address <= 4'h8 |-> avs_response == 2'b10;
  endproperty
  a_apar: assert property (p_apar) else $error("bad address parity not flagged");
  property p_unmap; ack && avs_address > 4'h8 |-> avs_response == 2'b11; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_rpar;
    avs_read && ack && avs_byteenable[0] |-> ^{avs_readdata[7:0], rdata_parity[0]};
  endproperty
  a_rpar: assert property (p_rpar) else $error("read parity wrong");
  property p_hi; avs_read && ack |-> avs_readdata[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper read lanes not zero");
  property p_irq0; irq_out == 8'h00; endproperty
  a_irq0: assert property (p_irq0) else $error("irq pin driven high");
  property p_irq1; $onehot0(~irq_oe_n); endproperty
  a_irq1: assert property (p_irq1) else $error("more than one irq line");
  property p_start; $fell(txd) |=> !txd [*8]; endproperty
  a_start: assert property (p_start) else $error("start bit too short");
endmodule
bind msc_channel msc_props chk_u (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .avs_response, .addr_parity, .rdata_parity, .irq_out, .irq_oe_n, .txd);

/* dv/msc_term_model.sv */
// terminal on the far side: sends frames on rxd, decodes nine bits after each start on txd
// assumes BIT clock cycles per bit (divisor 1)
`timescale 1ns/1ps
module msc_term_model #(
  parameter int BIT = 130
) (
  // clock and serial lines
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd,
  // last decoded frame and count
  output logic [8:0] seen,
  output int         n_seen
);
  initial begin
    rxd = 1'b1;
    seen = '0;
    n_seen = 0;
    forever begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge clk);
      repeat (9) begin
        repeat (BIT) @(posedge clk);
        seen = {txd, seen[8:1]};
      end
      n_seen++;
    end
  end
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
endmodule

/* dv/testbench.sv */
// register-level tests of one serial channel against a terminal model
// assumes divisor 1, so one bit is about 130 clocks
`timescale 1ns/1ps
module testbench;
  import msc_pkg::*;
  logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, addr_parity = 0;
  logic avs_waitrequest, txd, rxd;
  logic [3:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic [1:0] wdata_parity = '0, avs_response, rdata_parity;
  logic [7:0] irq_out, irq_oe_n;
  logic [8:0] seen;
  int n_seen, n_errors = 0, num_checks = 0;
  msc_modem_out_t modem_out;
  msc_modem_in_t mdm_in = '0;
  logic [3:0] be = 4'h3;
  always #5 clk = ~clk;
  msc_channel #(.CHAN_ID(8'h2c)) dut_u (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(be), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .addr_parity(addr_parity), .wdata_parity(wdata_parity),
    .rdata_parity(rdata_parity), .irq_out(irq_out), .irq_oe_n(irq_oe_n), .txd(txd),
    .rxd(rxd), .modem_out(modem_out), .modem_in(mdm_in));
  msc_term_model m_u (.clk(clk), .txd(txd), .rxd(rxd), .seen(seen), .n_seen(n_seen));
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic bad);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0000_00, d};
    addr_parity <= ~^a ^ bad;
    wdata_parity <= {1'b0, ~^d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n);
    bus(1'b0, a, 8'h00, 1'b0);
    chk(n, e, q[15:0]);
  endtask
  task automatic test_done;
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #500us;
    n_errors++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(4'h5, 16'h0060, "lstat reset");
    rd(4'h8, 16'h2c08, "adapter ctl");
    rd(4'h9, 16'h0000, "unmapped");
    chk("unmapped resp", 16'h0003, {14'h0, avs_response});
    bus(1'b1, 4'h7, 8'h5a, 1'b0);
    bus(1'b0, 4'h7, 8'h00, 1'b1);
    chk("bad parity resp", 16'h0002, {14'h0, avs_response});
    be <= 4'h1;
    rd(4'h8, 16'h0018, "apar flag 8-bit");
    be <= 4'h3;
    rd(4'h7, 16'h005a, "scratch");
    bus(1'b1, 4'h3, 8'h80, 1'b0);
    bus(1'b1, 4'h0, 8'h01, 1'b0);
    bus(1'b1, 4'h1, 8'h00, 1'b0);
    bus(1'b1, 4'h3, 8'h03, 1'b0);
    bus(1'b1, 4'h1, 8'h03, 1'b0);
    bus(1'b1, 4'h0, 8'h55, 1'b0);
    wait (n_seen == 1);
    chk("tx 8n1", 16'h0155, {7'h00, seen});
    bus(1'b1, 4'h3, 8'h1a, 1'b0);
    bus(1'b1, 4'h0, 8'h31, 1'b0);
    wait (n_seen == 2);
    chk("tx 7e1", 16'h01b1, {7'h00, seen});
    bus(1'b1, 4'h3, 8'h03, 1'b0);
    m_u.send(8'ha5, 1'b1);
    @(negedge clk);
    chk("irq line", 16'h00fe, {8'h00, irq_oe_n});
    rd(4'h5, 16'h0061, "data ready");
    rd(4'h2, 16'h0004, "int id rx");
    rd(4'h0, 16'h00a5, "rx data");
    rd(4'h2, 16'h0002, "int id thre");
    m_u.send(8'h3c, 1'b0);
    rd(4'h5, 16'h0069, "framing");
    mdm_in <= 4'h1;
    rd(4'h6, 16'h0011, "modem status");
    bus(1'b1, 4'h4, 8'h03, 1'b0);
    @(negedge clk);
    chk("modem out", 16'h0003, {14'h0, modem_out});
    test_done;
  end
endmodule
